// ===== shared/gpt_pkg.sv
/*
 * constants for the general-purpose 8-bit timer and event counter.
 * assumes a 32-bit apb slave; each printed offset is a register index,
 * the byte address is four times the index.
 */
package gpt_pkg;
    // ************************************************
    // widths
    // ************************************************
    localparam int unsigned GPT_ADDR_W = 12;
    localparam int unsigned GPT_CNT_W = 8;
    localparam int unsigned GPT_PRE_W = 6;
    // ************************************************
    // register indices and byte addresses
    // ************************************************
    localparam logic [GPT_ADDR_W-1:0] GPT_IDX_INTCTL = 12'h04E;
    localparam logic [GPT_ADDR_W-1:0] GPT_IDX_CTL = 12'h16A;
    localparam logic [GPT_ADDR_W-1:0] GPT_IDX_EVC = 12'h16B;
    localparam logic [GPT_ADDR_W-1:0] GPT_IDX_TMC = 12'h16C;
    localparam logic [GPT_ADDR_W-1:0] GPT_IDX_TMR = 12'h16D;
    localparam logic [GPT_ADDR_W-1:0] GPT_ADR_INTCTL = GPT_IDX_INTCTL << 2;
    localparam logic [GPT_ADDR_W-1:0] GPT_ADR_CTL = GPT_IDX_CTL << 2;
    localparam logic [GPT_ADDR_W-1:0] GPT_ADR_EVC = GPT_IDX_EVC << 2;
    localparam logic [GPT_ADDR_W-1:0] GPT_ADR_TMC = GPT_IDX_TMC << 2;
    localparam logic [GPT_ADDR_W-1:0] GPT_ADR_TMR = GPT_IDX_TMR << 2;
    // ************************************************
    // reset values
    // ************************************************
    localparam logic [7:0] GPT_RST_INTCTL = 8'hF0;
    localparam logic [7:0] GPT_RST_CTL = 8'h30;
    localparam logic [7:0] GPT_RST_CNT = 8'h00;
    localparam logic [7:0] GPT_CNT_ONE = 8'h01;
    localparam logic [7:0] GPT_CNT_MAX = 8'hFF;
    localparam logic [GPT_PRE_W-1:0] GPT_PRE_ONE = 6'h01;
    localparam logic [GPT_PRE_W-1:0] GPT_PRE_ZERO = 6'h00;
    // ************************************************
    // field positions
    // ************************************************
    localparam int unsigned GPT_B_TEN = 0;
    localparam int unsigned GPT_B_TFLG = 1;
    localparam int unsigned GPT_B_EEN = 2;
    localparam int unsigned GPT_B_EFLG = 3;
    localparam logic [3:0] GPT_INT_HI = 4'hF;
    localparam int unsigned GPT_B_TRUN = 3;
    localparam int unsigned GPT_B_EEDGE = 4;
    localparam int unsigned GPT_B_ESTOP = 5;
    localparam logic [7:0] GPT_CTL_MASK = 8'h3F;
    // ************************************************
    // timer clock select codes
    // ************************************************
    localparam logic [2:0] GPT_SEL_TB = 3'h6;
    localparam logic [2:0] GPT_SEL_EXT = 3'h7;
endpackage

// ===== hw/gpt_top.sv
/*
 * general-purpose 8-bit auto-reload timer and 8-bit event counter
 * behind an apb slave, with one shared interrupt request.
 * assumes inputs synchronous to mclk except the two count pins,
 * and a one-cycle soft_reset pulse for break, watchdog and trap.
 */
`timescale 1ns/1ps

// Contract
// R01: timer is 8-bit up counter, overflow requests
// R02: overflow reloads timer from reload register
// R03: low three control bits pick timer clock
// R04: control low nibble timer, bits 5:4 event
// R05: any reset clears timer and stops it
// R06: any reset clears reload register
// R07: control register resets to 30h
// R08: external select counts timer pin edges
// R09: stop mode, external timer counts falling edges
// R10: stop mode change may add one count
// R11: event counter 8-bit, overflow requests
// R12: control bits 5:4 pick event clock
// R13: any reset clears event counter, stops
// R14: event counter counts its pin edges
// R15: stop mode, event counts falling edges
// R16: both requests share one interrupt output
// R17: interrupt bit 0 enables timer request
// R18: interrupt bit 1 shows timer request
// R19: interrupt bit 2 enables event request
// R20: interrupt bit 3 shows event request
// R21: interrupt register resets to f0h
// R22: flags set always, gated, cleared by zero
// R23: pins synchronised, edges found in mclk
module gpt_top
    import gpt_pkg::*;
#(
    parameter int unsigned PRE_W = GPT_PRE_W
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic soft_reset,
    input wire logic stop_mode,
    input wire logic time_base_clock,
    input wire logic external_timer_clock_pin,
    input wire logic external_event_clock_pin,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [GPT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    // ************************************************
    // state
    // ************************************************
    logic [7:0] ctl_r;
    logic [7:0] tmc_r;
    logic [7:0] tmc_nxt;
    logic [7:0] tmr_r;
    logic [7:0] evc_r;
    logic [7:0] evc_nxt;
    logic ten_r;
    logic tflg_r;
    logic een_r;
    logic eflg_r;
    logic [PRE_W-1:0] pre_r;
    logic [31:0] prdata_r;
    logic t_s1_r;
    logic t_s2_r;
    logic t_s3_r;
    logic e_s1_r;
    logic e_s2_r;
    logic e_s3_r;

    // ************************************************
    // apb decode
    // ************************************************
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire hit_int = (paddr == GPT_ADR_INTCTL);
    wire hit_ctl = (paddr == GPT_ADR_CTL);
    wire hit_evc = (paddr == GPT_ADR_EVC);
    wire hit_tmc = (paddr == GPT_ADR_TMC);
    wire hit_tmr = (paddr == GPT_ADR_TMR);
    wire hit_any = hit_int | hit_ctl | hit_evc | hit_tmc | hit_tmr;
    wire wr_int = wr & hit_int;
    wire wr_ctl = wr & hit_ctl;
    wire wr_evc = wr & hit_evc;
    wire wr_tmc = wr & hit_tmc;
    wire wr_tmr = wr & hit_tmr;
    wire [7:0] wbyte = pwdata[7:0];

    assign pready = 1'b1;
    assign pslverr = access & ~hit_any;
    assign prdata = prdata_r;

    // ************************************************
    // control fields
    // ************************************************
    // timer clock select in bits 2:0, run in bit 3
    wire [2:0] t_sel = ctl_r[2:0]; // [R03] [R04]
    wire t_run = ctl_r[GPT_B_TRUN]; // [R04]
    // event edge in bit 4 (1 rising), stop in bit 5
    wire e_rise_sel = ctl_r[GPT_B_EEDGE]; // [R12]
    wire e_run = ~ctl_r[GPT_B_ESTOP]; // [R12] [R04]

    // ************************************************
    // pin synchronisers
    // ************************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            t_s1_r <= 1'b0;
            t_s2_r <= 1'b0;
            t_s3_r <= 1'b0;
            e_s1_r <= 1'b0;
            e_s2_r <= 1'b0;
            e_s3_r <= 1'b0;
        end else begin
            t_s1_r <= external_timer_clock_pin; // [R23]
            t_s2_r <= t_s1_r;
            t_s3_r <= t_s2_r;
            e_s1_r <= external_event_clock_pin; // [R23]
            e_s2_r <= e_s1_r;
            e_s3_r <= e_s2_r;
        end
    end

    // edge detect past the second stage only
    wire t_rise = t_s2_r & ~t_s3_r; // [R23]
    wire t_fall = ~t_s2_r & t_s3_r;
    wire e_rise = e_s2_r & ~e_s3_r; // [R23]
    wire e_fall = ~e_s2_r & e_s3_r;

    // stop mode forces falling edges on both pins; one edge may count at the change
    wire t_ext_tick = stop_mode ? t_fall : t_rise; // [R08] [R09] [R10]
    wire e_pol_rise = e_rise_sel & ~stop_mode; // [R15] [R10]
    wire e_tick = e_pol_rise ? e_rise : e_fall; // [R14] [R15]

    // ************************************************
    // time base prescaler
    // ************************************************
    logic [PRE_W-1:0] taps;

    generate
        for (genvar k = 0; k < PRE_W; k++) begin : g_tap
            assign taps[k] = time_base_clock & (&pre_r[k:0]);
        end
    endgenerate

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pre_r <= GPT_PRE_ZERO;
        end else if (soft_reset) begin
            pre_r <= GPT_PRE_ZERO;
        end else if (time_base_clock) begin
            pre_r <= pre_r + GPT_PRE_ONE;
        end
    end

    // codes 0..5 divide the time base by 2..64
    wire t_div_tick = (t_sel < 3'(PRE_W)) ? taps[t_sel] : 1'b0;
    wire t_src = (t_sel == GPT_SEL_EXT) ? t_ext_tick :
                 (t_sel == GPT_SEL_TB) ? time_base_clock :
                 t_div_tick; // [R03]

    // ************************************************
    // counters
    // ************************************************
    wire t_tick = t_run & t_src;
    wire t_ovf = t_tick & (tmc_r == GPT_CNT_MAX) & ~wr_tmc; // [R01]
    wire e_cnt = e_run & e_tick;
    wire e_ovf = e_cnt & (evc_r == GPT_CNT_MAX) & ~wr_evc; // [R11]

    always_comb begin
        tmc_nxt = tmc_r;
        if (wr_tmc) begin
            tmc_nxt = wbyte;
        end else if (t_ovf) begin
            tmc_nxt = tmr_r; // [R02]
        end else if (t_tick) begin
            tmc_nxt = tmc_r + GPT_CNT_ONE; // [R01]
        end
    end

    always_comb begin
        evc_nxt = evc_r;
        if (wr_evc) begin
            evc_nxt = wbyte;
        end else if (e_cnt) begin
            evc_nxt = evc_r + GPT_CNT_ONE; // [R11]
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tmc_r <= GPT_RST_CNT;
            evc_r <= GPT_RST_CNT;
        end else if (soft_reset) begin
            tmc_r <= GPT_RST_CNT; // [R05]
            evc_r <= GPT_RST_CNT; // [R13]
        end else begin
            tmc_r <= tmc_nxt;
            evc_r <= evc_nxt;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tmr_r <= GPT_RST_CNT;
            ctl_r <= GPT_RST_CTL;
        end else if (soft_reset) begin
            tmr_r <= GPT_RST_CNT; // [R06]
            ctl_r <= GPT_RST_CTL; // [R07] [R05] [R13]
        end else begin
            if (wr_tmr) begin
                tmr_r <= wbyte;
            end
            if (wr_ctl) begin
                ctl_r <= wbyte & GPT_CTL_MASK;
            end
        end
    end

    // ************************************************
    // interrupt control
    // ************************************************
    // a write of zero clears a flag, an overflow in the same cycle wins
    wire tflg_clr = wr_int & ~wbyte[GPT_B_TFLG];
    wire eflg_clr = wr_int & ~wbyte[GPT_B_EFLG];

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ten_r <= GPT_RST_INTCTL[GPT_B_TEN];
            tflg_r <= GPT_RST_INTCTL[GPT_B_TFLG];
            een_r <= GPT_RST_INTCTL[GPT_B_EEN];
            eflg_r <= GPT_RST_INTCTL[GPT_B_EFLG];
        end else if (soft_reset) begin
            ten_r <= GPT_RST_INTCTL[GPT_B_TEN]; // [R21]
            tflg_r <= GPT_RST_INTCTL[GPT_B_TFLG];
            een_r <= GPT_RST_INTCTL[GPT_B_EEN];
            eflg_r <= GPT_RST_INTCTL[GPT_B_EFLG];
        end else begin
            if (wr_int) begin
                ten_r <= wbyte[GPT_B_TEN]; // [R17]
                een_r <= wbyte[GPT_B_EEN]; // [R19]
            end
            tflg_r <= t_ovf | (tflg_r & ~tflg_clr); // [R18] [R22]
            eflg_r <= e_ovf | (eflg_r & ~eflg_clr); // [R20] [R22]
        end
    end

    wire [7:0] int_rd = {GPT_INT_HI, eflg_r, een_r, tflg_r, ten_r}; // [R21]

    // one shared request line for both sources
    assign irq = (tflg_r & ten_r) | (eflg_r & een_r); // [R16] [R22]

    // ************************************************
    // read data
    // ************************************************
    wire [7:0] rd_sel = hit_int ? int_rd :
                        hit_ctl ? ctl_r :
                        hit_evc ? evc_r :
                        hit_tmc ? tmc_r :
                        hit_tmr ? tmr_r :
                        GPT_RST_CNT;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prdata_r <= 32'h00000000;
        end else if (setup & ~pwrite) begin
            prdata_r <= {24'h000000, rd_sel};
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    sequence s_t_wrap;
        t_ovf && !soft_reset;
    endsequence

    sequence s_e_wrap;
        e_ovf && !soft_reset;
    endsequence

    sequence s_epin_rise;
        !external_event_clock_pin ##1 external_event_clock_pin [*2];
    endsequence

    chk_tmr_reload: assert property ( // [R02]
        s_t_wrap |=> (tmc_r == $past(tmr_r))
    ) else $error("timer did not reload on overflow");

    chk_tmr_flag: assert property ( // [R01]
        s_t_wrap |=> tflg_r
    ) else $error("timer overflow did not set its flag");

    chk_evc_wrap: assert property ( // [R11]
        s_e_wrap |=> (evc_r == GPT_RST_CNT) && eflg_r
    ) else $error("event counter overflow wrong");

    chk_flag_set_wins: assert property ( // [R22]
        s_t_wrap ##0 tflg_clr |=> tflg_r
    ) else $error("overflow lost against a clear");

    chk_irq_shared: assert property ( // [R16]
        (eflg_r && een_r) || (tflg_r && ten_r) |-> irq
    ) else $error("enabled request not on irq");

    chk_soft_reset: assert property ( // [R05]
        soft_reset |=> (tmc_r == GPT_RST_CNT) && (evc_r == GPT_RST_CNT)
            && (tmr_r == GPT_RST_CNT) && (ctl_r == GPT_RST_CTL)
            && (int_rd == GPT_RST_INTCTL)
    ) else $error("soft reset values wrong");

    chk_tmr_stopped: assert property ( // [R05]
        !t_run && !wr_tmc && !soft_reset |=> $stable(tmc_r)
    ) else $error("stopped timer moved");

    chk_ext_count: assert property ( // [R08]
        (t_sel == GPT_SEL_EXT) && t_run && t_ext_tick && !wr_tmc
            && (tmc_r != GPT_CNT_MAX) && !soft_reset
            |=> (tmc_r == $past(tmc_r) + GPT_CNT_ONE)
    ) else $error("external timer edge not counted");

    chk_stop_fall: assert property ( // [R15]
        stop_mode && e_run && e_rise && !e_fall && !wr_evc && !soft_reset
            |=> $stable(evc_r)
    ) else $error("event counted a rising edge in stop mode");

    chk_pin_sync: assert property ( // [R23]
        s_epin_rise |=> e_rise
    ) else $error("event pin edge not detected after two stages");

    chk_evc_stopped: assert property ( // [R13]
        !e_run && !wr_evc && !soft_reset |=> $stable(evc_r)
    ) else $error("stopped event counter moved");

    chk_tmr_stop_edge: assert property ( // [R09]
        stop_mode && (t_sel == GPT_SEL_EXT) && t_run && t_rise && !wr_tmc && !soft_reset
            |=> $stable(tmc_r)
    ) else $error("timer counted a rising edge in stop mode");

    chk_evc_count: assert property ( // [R14]
        e_run && e_tick && !wr_evc && (evc_r != GPT_CNT_MAX) && !soft_reset
            |=> (evc_r == $past(evc_r) + GPT_CNT_ONE)
    ) else $error("event edge not counted");

    chk_irq_quiet: assert property ( // [R17] [R19]
        !(tflg_r && ten_r) && !(eflg_r && een_r) |-> !irq
    ) else $error("irq high without an enabled request");

    chk_div_hold: assert property ( // [R03]
        t_run && (t_sel < GPT_SEL_TB) && !time_base_clock && !wr_tmc && !soft_reset
            |=> $stable(tmc_r)
    ) else $error("divided timer moved without a time base tick");

    chk_tb_count: assert property ( // [R03]
        t_run && (t_sel == GPT_SEL_TB) && time_base_clock && !wr_tmc
            && (tmc_r != GPT_CNT_MAX) && !soft_reset
            |=> (tmc_r == $past(tmc_r) + GPT_CNT_ONE)
    ) else $error("time base tick not counted");

endmodule

// ===== testbench/gpt_pin_model.sv
/*
 * model of the two external count sources in front of the timer block.
 * assumes it is driven from the bench by task calls; pins stand still between calls.
 */
`timescale 1ns/1ps

module gpt_pin_model (
    input wire logic mclk,
    output logic tmr_pin,
    output logic evt_pin
);
    // ************************************************
    // pin driving
    // ************************************************
    initial begin
        tmr_pin = 1'b0;
        evt_pin = 1'b0;
    end

    // set both pins and hold the level for hold mclk cycles, at least two
    task automatic set_pins(input logic t, input logic e, input int hold);
        @(posedge mclk);
        tmr_pin <= t;
        evt_pin <= e;
        repeat (hold) @(posedge mclk);
    endtask

    // n full pulses on the selected pins, ending low
    task automatic pulse(input int n, input logic t, input logic e, input int hold);
        repeat (n) begin
            set_pins(t, e, hold);
            set_pins(1'b0, 1'b0, hold);
        end
    endtask
endmodule

// ===== testbench/testbench.sv
/*
 * self-checking bench for the timer and event counter, with a register model.
 * assumes a zero wait state apb slave and pins modelled by gpt_pin_model.
 */
`timescale 1ns/1ps

`define CHK(n, x, s) begin cmp_count++; if ((s) !== (x)) begin num_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", n, x, s); end end

module testbench
    import gpt_pkg::*;
;
    // ************************************************
    // signals and model state
    // ************************************************
    logic mclk = 1'b0, resetn = 1'b0, soft_reset = 1'b0, stop_mode = 1'b0, time_base_clock = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, tmr_pin, evt_pin, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    integer seed = 32'h1e26;
    int tm, rl, ev, ct, ic, cyc = 0, num_errors = 0, cmp_count = 0;

    always #12.5 mclk = ~mclk;

    gpt_top #(.PRE_W(GPT_PRE_W)) i_gpt_top (.mclk(mclk), .resetn(resetn), .soft_reset(soft_reset),
        .stop_mode(stop_mode), .time_base_clock(time_base_clock), .external_timer_clock_pin(tmr_pin),
        .external_event_clock_pin(evt_pin), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    gpt_pin_model i_gpt_pin_model (.mclk(mclk), .tmr_pin(tmr_pin), .evt_pin(evt_pin));

    // ************************************************
    // tasks
    // ************************************************
    task report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'($random(seed)), d};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w) begin
            case (a)
                GPT_ADR_INTCTL: ic = (d & 5) | (ic & d & 10);
                GPT_ADR_CTL: ct = d & GPT_CTL_MASK;
                GPT_ADR_EVC: ev = d;
                GPT_ADR_TMC: tm = d;
                GPT_ADR_TMR: rl = d;
                default: ;
            endcase
        end
    endtask

    task automatic rd(input logic [11:0] a, input int x, input string nm);
        apb(1'b0, a, 8'h00);
        `CHK(nm, 32'(x), r)
    endtask

    task automatic chk_all();
        rd(GPT_ADR_TMC, tm, "timer");
        rd(GPT_ADR_EVC, ev, "event");
        rd(GPT_ADR_TMR, rl, "reload");
        rd(GPT_ADR_CTL, ct, "control");
        rd(GPT_ADR_INTCTL, 32'hF0 | ic, "intctl");
        `CHK("irq", 1'(((ic & 3) == 3) || ((ic & 12) == 12)), irq)
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge mclk);
            time_base_clock <= 1'b1;
            @(posedge mclk);
            time_base_clock <= 1'b0;
        end
        repeat (3) @(posedge mclk);
    endtask

    function automatic void t_tick();
        if (tm == 255) begin
            tm = rl;
            ic |= 2;
        end else begin
            tm++;
        end
    endfunction

    function automatic void e_tick();
        if (ev == 255) begin
            ev = 0;
            ic |= 8;
        end else begin
            ev++;
        end
    endfunction

    function automatic void mrst();
        tm = 0;
        rl = 0;
        ev = 0;
        ct = 8'h30;
        ic = 0;
    endfunction

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 12000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        mrst();
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        chk_all();
        apb(1'b1, 12'h004, 8'h5A);
        `CHK("slverr_w", 1'b1, e)
        rd(12'h004, 0, "unmapped");
        apb(1'b1, GPT_ADR_TMR, 8'($random(seed)));
        apb(1'b1, GPT_ADR_TMC, 8'hFE);
        apb(1'b1, GPT_ADR_CTL, 8'h2F);
        apb(1'b1, GPT_ADR_INTCTL, 8'h01);
        i_gpt_pin_model.pulse(3, 1'b1, 1'b0, 3);
        repeat (3) t_tick();
        chk_all();
        apb(1'b1, GPT_ADR_EVC, 8'hFF);
        apb(1'b1, GPT_ADR_CTL, 8'h10);
        apb(1'b1, GPT_ADR_INTCTL, 8'h06);
        i_gpt_pin_model.pulse(2, 1'b0, 1'b1, 5);
        repeat (2) e_tick();
        chk_all();
        apb(1'b1, GPT_ADR_CTL, 8'h00);
        apb(1'b1, GPT_ADR_EVC, 8'h40);
        i_gpt_pin_model.set_pins(1'b0, 1'b1, 3);
        rd(GPT_ADR_EVC, ev, "event_rise");
        i_gpt_pin_model.set_pins(1'b0, 1'b0, 3);
        e_tick();
        rd(GPT_ADR_EVC, ev, "event_fall");
        apb(1'b1, GPT_ADR_INTCTL, 8'h0B);
        chk_all();
        apb(1'b1, GPT_ADR_INTCTL, 8'h05);
        chk_all();
        apb(1'b1, GPT_ADR_TMC, 8'hFF);
        apb(1'b1, GPT_ADR_CTL, 8'h2E);
        fork
            apb(1'b1, GPT_ADR_INTCTL, 8'h05);
            begin
                repeat (2) @(posedge mclk);
                time_base_clock <= 1'b1;
                @(posedge mclk);
                time_base_clock <= 1'b0;
            end
        join
        t_tick();
        chk_all();
        apb(1'b1, GPT_ADR_CTL, 8'h1F);
        @(posedge mclk);
        stop_mode <= 1'b1;
        apb(1'b1, GPT_ADR_TMC, 8'h10);
        apb(1'b1, GPT_ADR_EVC, 8'h20);
        i_gpt_pin_model.set_pins(1'b1, 1'b1, 3);
        chk_all();
        i_gpt_pin_model.set_pins(1'b0, 1'b0, 3);
        t_tick();
        e_tick();
        chk_all();
        @(posedge mclk);
        stop_mode <= 1'b0;
        for (int s = 0; s < 7; s++) begin
            apb(1'b1, GPT_ADR_TMC, 8'h00);
            apb(1'b1, GPT_ADR_CTL, 8'(8'h28 | s));
            ticks(64);
            apb(1'b1, GPT_ADR_CTL, 8'h20);
            repeat ((s == 6) ? 64 : (64 >> (s + 1))) t_tick();
            rd(GPT_ADR_TMC, tm, "prescale");
        end
        ticks(8);
        chk_all();
        apb(1'b1, GPT_ADR_TMR, 8'h77);
        @(posedge mclk);
        soft_reset <= 1'b1;
        @(posedge mclk);
        soft_reset <= 1'b0;
        mrst();
        chk_all();
        ticks(8);
        i_gpt_pin_model.pulse(2, 1'b1, 1'b1, 2);
        chk_all();
        report_and_stop();
    end
endmodule
